// File: nvsrs_pkg.sv
// constants and types for the store/recall sequencer
// assumes a 40 MHz core clock; durations are max figures rounded down
package nvsrs_pkg;
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   // write-continuation window before a power-loss store starts
   localparam int WR_DELAY_NS = 25;
   localparam int WR_DELAY_CYC = (WR_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (WR_DELAY_NS / CLK_PERIOD_NS);
   // software command processing time
   localparam int SEQ_PROC_US = 500;
   localparam int SEQ_PROC_CYC = SEQ_PROC_US * CLK_MHZ;
   // software recall duration
   localparam int RECALL_US = 600;
   localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
   // power-up recall duration
   localparam int POWERUP_RECALL_MS = 20;
   localparam int POWERUP_RECALL_CYC = POWERUP_RECALL_MS * 1000 * CLK_MHZ;
   // store cycle duration
   localparam int STORE_MS = 8;
   localparam int STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
   localparam int TMR_W = 20;

   typedef enum logic [2:0] {
      NVSRS_LOW,
      NVSRS_PU_RECALL,
      NVSRS_IDLE,
      NVSRS_CMD_PROC,
      NVSRS_SW_STORE,
      NVSRS_SW_RECALL,
      NVSRS_WR_WINDOW,
      NVSRS_PL_STORE
   } nvsrs_state_t;
endpackage

// File: nvsrs_timer.sv
// down-counting cycle timer with one-cycle done pulse
// assumes load and count come from the sequencer in the same clock
`timescale 1ns/10ps
module nvsrs_timer #(
   parameter int W = 20
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   output logic done_o,
   output logic busy_o
);
   logic [W-1:0] cnt_ff;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= '0;
         done_o <= 1'b0;
      end
      else if (load_i)
      begin
         cnt_ff <= count_i;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
         if (cnt_ff != '0)
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign busy_o = (cnt_ff != '0);
endmodule

// File: nvsrs_top.sv
// nonvolatile store/recall sequencer: power-up recall, power-loss store,
// software store/recall and host access lockout
// assumes supply detect and host strobes are synchronous to clk_i
//
// What this block does
// - skip power-loss store when array is clean
// - keep writes enabled briefly after power loss, the last reaching the array in the first power-loss store cycle
// - ignore host cycles during transfer or low supply, except writes in the write window
// - command transfers lock I/O; recall within 600us
// - act on software command within 500us
// - power-up recall timed from supply rise
// - write window lasts at most 25ns
`timescale 1ns/10ps
module nvsrs_top
   import nvsrs_pkg::*;
#(
   parameter int SEQ_PROC_CYCLES = SEQ_PROC_CYC,
   parameter int RECALL_CYCLES = RECALL_CYC,
   parameter int PU_RECALL_CYCLES = POWERUP_RECALL_CYC,
   parameter int STORE_CYCLES = STORE_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic vcc_ok_i,
   input wire logic power_loss_store_en_i,
   input wire logic sw_store_i,
   input wire logic sw_recall_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   output logic array_rd_en_o,
   output logic array_wr_en_o,
   output logic nv_store_o,
   output logic nv_recall_o,
   output logic busy_o,
   output logic dirty_o
);
   import nvsrs_pkg::*;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_s1_ff;
   logic rst_n_ff;
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // state and timer
   // ---------------------------------------------------------------
   nvsrs_state_t state_ff;
   nvsrs_state_t nxt_state;
   logic pend_store_ff;
   logic dirty_ff;
   logic tmr_load;
   logic [TMR_W-1:0] tmr_count;
   logic tmr_done;
   logic tmr_busy;

   nvsrs_timer #(
      .W(TMR_W)
   ) u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_ff),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .done_o(tmr_done),
      .busy_o(tmr_busy)
   );

   wire power_fail = !vcc_ok_i;
   wire want_pl_store = power_loss_store_en_i && dirty_ff;

   always_comb
   begin
      nxt_state = state_ff;
      tmr_load = 1'b0;
      tmr_count = '0;
      case (state_ff)
         NVSRS_LOW:
            if (vcc_ok_i)
            begin
               // recall timed from supply rising above trigger
               nxt_state = NVSRS_PU_RECALL;
               tmr_load = 1'b1;
               tmr_count = TMR_W'(PU_RECALL_CYCLES);
            end
         NVSRS_PU_RECALL:
            if (power_fail)
               nxt_state = NVSRS_LOW;
            else if (tmr_done)
               nxt_state = NVSRS_IDLE;
         NVSRS_IDLE:
            if (power_fail)
            begin
               nxt_state = want_pl_store ? NVSRS_WR_WINDOW : NVSRS_LOW;
               tmr_load = want_pl_store;
               // load n-1 and leave on idle timer: n cycles of writes, not n+1
               tmr_count = TMR_W'(WR_DELAY_CYC - 1);
            end
            else if (sw_store_i || sw_recall_i)
            begin
               nxt_state = NVSRS_CMD_PROC;
               tmr_load = 1'b1;
               tmr_count = TMR_W'(SEQ_PROC_CYCLES);
            end
         NVSRS_CMD_PROC:
            if (power_fail)
               nxt_state = NVSRS_LOW; // command needs supply held high
            else if (tmr_done)
            begin
               nxt_state = pend_store_ff ? NVSRS_SW_STORE : NVSRS_SW_RECALL;
               tmr_load = 1'b1;
               tmr_count = pend_store_ff ? TMR_W'(STORE_CYCLES) : TMR_W'(RECALL_CYCLES);
            end
         NVSRS_SW_STORE, NVSRS_SW_RECALL, NVSRS_PL_STORE:
            // store finishes on held-up charge; recall aborted by supply loss
            if (tmr_done)
               nxt_state = power_fail ? NVSRS_LOW : NVSRS_IDLE;
            else if (power_fail && state_ff == NVSRS_SW_RECALL)
               nxt_state = NVSRS_LOW;
         NVSRS_WR_WINDOW:
            if (!tmr_busy)
            begin
               nxt_state = NVSRS_PL_STORE;
               tmr_load = 1'b1;
               tmr_count = TMR_W'(STORE_CYCLES);
            end
         default:
            nxt_state = NVSRS_LOW;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         state_ff <= NVSRS_LOW;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         pend_store_ff <= 1'b0;
      else if (state_ff == NVSRS_IDLE && (sw_store_i || sw_recall_i))
         pend_store_ff <= sw_store_i; // store wins if both arrive together
   end

   // ---------------------------------------------------------------
   // host gating and dirty tracking
   // ---------------------------------------------------------------
   wire open_nxt = (nxt_state == NVSRS_IDLE || nxt_state == NVSRS_CMD_PROC) && vcc_ok_i;
   // judged on the next state so no write lands in the cycle a transfer starts, except a window write as the power-loss store starts
   wire wr_taken = host_wr_i && (open_nxt || state_ff == NVSRS_WR_WINDOW);
   wire nv_done = tmr_done &&
      (state_ff == NVSRS_SW_STORE || state_ff == NVSRS_SW_RECALL ||
       state_ff == NVSRS_PL_STORE || state_ff == NVSRS_PU_RECALL);

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         dirty_ff <= 1'b0;
      else if (wr_taken)
         dirty_ff <= 1'b1;
      else if (nv_done)
         dirty_ff <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         array_rd_en_o <= 1'b0;
         array_wr_en_o <= 1'b0;
         nv_store_o <= 1'b0;
         nv_recall_o <= 1'b0;
         busy_o <= 1'b1;
         dirty_o <= 1'b0;
      end
      else
      begin
         array_rd_en_o <= host_rd_i && open_nxt && vcc_ok_i;
         array_wr_en_o <= wr_taken;
         nv_store_o <= (nxt_state == NVSRS_SW_STORE || nxt_state == NVSRS_PL_STORE);
         nv_recall_o <= (nxt_state == NVSRS_SW_RECALL || nxt_state == NVSRS_PU_RECALL);
         busy_o <= !open_nxt;
         dirty_o <= dirty_ff;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence pl_start_s;
      state_ff == NVSRS_IDLE && power_fail && want_pl_store;
   endsequence

   clean_skip_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == NVSRS_IDLE && power_fail && !dirty_ff |=> state_ff == NVSRS_LOW)
      else $error("clean array still stored");
   wr_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      pl_start_s |=> state_ff == NVSRS_WR_WINDOW ##1 state_ff == NVSRS_PL_STORE)
      else $error("write window wrong length");
   rd_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      !vcc_ok_i |=> !array_rd_en_o)
      else $error("read served with low supply");
   wr_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      host_wr_i && (state_ff == NVSRS_SW_STORE || state_ff == NVSRS_PL_STORE) |=> !array_wr_en_o)
      else $error("write served during store");
   sw_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == NVSRS_SW_RECALL |-> busy_o)
      else $error("no lockout during recall");
   cmd_act_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      $rose(state_ff == NVSRS_CMD_PROC) |-> tmr_busy)
      else $error("command timer not running");
   pu_recall_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == NVSRS_LOW && vcc_ok_i |=> state_ff == NVSRS_PU_RECALL && nv_recall_o && busy_o)
      else $error("power-up recall not started");
   recall_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == NVSRS_SW_RECALL && tmr_done && vcc_ok_i |=> state_ff == NVSRS_IDLE)
      else $error("recall did not finish on time");
endmodule

// File: nvsrs_host_model.sv
// serial host model: array read/write cycles and store/recall commands
// assumes it drives at the falling edge of clk_i and sits under tb_top
`timescale 1ns/10ps
module nvsrs_host_model (
   input wire logic clk_i,
   input wire logic busy_i,
   output logic host_rd_o,
   output logic host_wr_o,
   output logic sw_store_o,
   output logic sw_recall_o
);
   initial
   begin
      host_rd_o = 1'b0;
      host_wr_o = 1'b0;
      sw_store_o = 1'b0;
      sw_recall_o = 1'b0;
   end
   // ----------------------------------------
   // transfers
   // ----------------------------------------
   // impolite calls probe the refusal path on purpose
   task automatic access(input logic rd, input logic wr, input bit polite);
      int n;
      n = 0;
      while (polite && busy_i !== 1'b0 && n < 4000)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 4000)
      begin
         tb_top.errors++;
         tb_top.finish_test();
      end
      @(negedge clk_i);
      host_rd_o = rd;
      host_wr_o = wr;
      @(negedge clk_i);
      host_rd_o = 1'b0;
      host_wr_o = 1'b0;
   endtask
   task automatic command(input logic st, input logic rc);
      @(negedge clk_i);
      sw_store_o = st;
      sw_recall_o = rc;
      @(negedge clk_i);
      sw_store_o = 1'b0;
      sw_recall_o = 1'b0;
   endtask
   // caller is already at a falling edge
   task automatic burst_wr(input int n);
      host_wr_o = 1'b1;
      repeat (n) @(negedge clk_i);
      host_wr_o = 1'b0;
   endtask
endmodule

// File: tb_top.sv
// self-checking bench for the store/recall sequencer
// assumes shortened counts; inputs change at the falling edge
`timescale 1ns/10ps
module tb_top;
   import nvsrs_pkg::*;
   localparam int SEQ = 20;
   localparam int REC = 30;
   localparam int PU = 40;
   localparam int ST = 50;
   logic clk_i, nrst_i, vcc_ok_i, rd_en, wr_en, st_o, rc_o, busy, dirty;
   logic host_rd, host_wr, sw_st, sw_rc, r, w, dirty_exp, pl_store_en;
   int errors, check_count, n, k;
   nvsrs_top #(.SEQ_PROC_CYCLES(SEQ), .RECALL_CYCLES(REC), .PU_RECALL_CYCLES(PU), .STORE_CYCLES(ST)) uut (
      .clk_i(clk_i), .nrst_i(nrst_i), .vcc_ok_i(vcc_ok_i), .power_loss_store_en_i(pl_store_en),
      .sw_store_i(sw_st), .sw_recall_i(sw_rc), .host_rd_i(host_rd), .host_wr_i(host_wr),
      .array_rd_en_o(rd_en), .array_wr_en_o(wr_en), .nv_store_o(st_o), .nv_recall_o(rc_o),
      .busy_o(busy), .dirty_o(dirty));
   nvsrs_host_model host (.clk_i(clk_i), .busy_i(busy), .host_rd_o(host_rd), .host_wr_o(host_wr),
      .sw_store_o(sw_st), .sw_recall_o(sw_rc));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   function logic in_win(input int c, input int lo, input int hi);
      return (c >= lo && c <= hi);
   endfunction
   function logic sig(input int sel);
      case (sel)
         0: return busy;
         1: return rc_o;
         default: return st_o;
      endcase
   endfunction
   task automatic wait_on(input int sel, input logic lvl, input int bound, output int c);
      c = 0;
      while (sig(sel) !== lvl && c < bound)
      begin
         @(negedge clk_i);
         c++;
      end
      if (c >= bound)
      begin
         errors++;
         finish_test();
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      errors = 0;
      check_count = 0;
      nrst_i = 1'b0;
      vcc_ok_i = 1'b1;
      pl_store_en = 1'b1;
      dirty_exp = 1'b0;
      k = $urandom(32'h6d842714);
      repeat (12) @(negedge clk_i);
      nrst_i = 1'b1;
      wait_on(1, 1'b1, 10, n);
      host.access(1'b1, 1'b1, 1'b0);
      check(rd_en, 1'b0);
      check(wr_en, 1'b0);
      repeat (24)
      begin
         r = $urandom_range(1);
         w = $urandom_range(1);
         host.access(r, w, 1'b1);
         check(rd_en, r);
         check(wr_en, w);
         dirty_exp = dirty_exp | w;
      end
      // dirty_o trails the internal flag by one cycle
      @(negedge clk_i);
      check(dirty, dirty_exp);
      host.access(1'b0, 1'b1, 1'b1);
      host.command(1'b1, 1'b0);
      wait_on(2, 1'b1, SEQ + 5, n);
      check(in_win(n, 1, SEQ + 3), 1'b1);
      check(busy, 1'b1);
      wait_on(0, 1'b0, ST + 5, n);
      @(negedge clk_i);
      check(dirty, 1'b0);
      // clean array: supply loss must not start a store
      @(negedge clk_i);
      vcc_ok_i = 1'b0;
      host.access(1'b1, 1'b1, 1'b0);
      check(rd_en, 1'b0);
      check(wr_en, 1'b0);
      k = 0;
      repeat (10) @(negedge clk_i) k += st_o;
      check(k, 0);
      @(negedge clk_i);
      vcc_ok_i = 1'b1;
      wait_on(1, 1'b1, 10, k);
      wait_on(1, 1'b0, PU + 10, n);
      check(in_win(k + n, PU, PU + 4), 1'b1);
      host.access(1'b1, 1'b0, 1'b1);
      check(rd_en, 1'b1);
      host.command(1'b0, 1'b1);
      wait_on(1, 1'b1, SEQ + 5, n);
      check(in_win(n, 1, SEQ + 3), 1'b1);
      host.access(1'b0, 1'b1, 1'b0);
      check(wr_en, 1'b0);
      wait_on(0, 1'b0, REC + 5, n);
      check(in_win(n + 2, REC - 2, REC + 3), 1'b1);
      host.access(1'b0, 1'b1, 1'b1);
      @(negedge clk_i);
      check(dirty, 1'b1);
      // store disabled: a dirty array is not stored at power loss
      pl_store_en = 1'b0;
      vcc_ok_i = 1'b0;
      k = 0;
      repeat (10) @(negedge clk_i) k += st_o;
      check(k, 0);
      vcc_ok_i = 1'b1;
      pl_store_en = 1'b1;
      wait_on(1, 1'b1, 10, n);
      wait_on(1, 1'b0, PU + 10, n);
      @(negedge clk_i);
      check(dirty, 1'b0);
      host.access(1'b0, 1'b1, 1'b1);
      @(negedge clk_i);
      check(dirty, 1'b1);
      // dirty array: writes run on briefly, then the store locks them out
      @(negedge clk_i);
      vcc_ok_i = 1'b0;
      k = 0;
      fork
         host.burst_wr(6);
         repeat (6) @(negedge clk_i) k += wr_en;
      join
      check(in_win(k, 1, WR_DELAY_CYC), 1'b1);
      wait_on(2, 1'b1, 5, n);
      check(busy, 1'b1);
      wait_on(2, 1'b0, ST + 5, n);
      check(busy, 1'b1);
      finish_test();
   end
endmodule
